// ==== hw/misc_enable_pkg.sv ====
// package: register map, field positions, reset values and bus codes for the feature/branch register bank
//
// Notes on behaviour
// [R1] second throttle enabled and sensor hot: apply last thermal control low setting.
// [R2] second throttle enable resets to zero; when clear the ratio/voltage stay unchanged.
// [R3] firmware leaves the second throttle enable alone unless leaf 1 reports it.
// [R4] software must not leave both thermal throttle enables cleared together.
// [R5] feature bit 16 read-write, turns on frequency-voltage stepping when one.
// [R6] feature bit 18 read-write, enables the monitor/wait state machine when one.
// [R7] feature bit 22 read-write, limits the reported highest identification leaf to 3.
// [R8] feature bit 34 read-write, disables execute-disable page protection when one.
// [R9] read-only top index register shows the newest branch record slot in bits 3:0.
// [R10] read-write debug control register steering the debug features.
// [R11] read-only register holds source of last branch before latest exception or interrupt.
// [R12] read-only register holds target of that same last branch.
// [R13] feature bit 3 read-write, enables the first automatic thermal control circuit.
// [R14] reserved feature bits read as zero and ignore writes.
package misc_enable_pkg;

  // ==========================================================================
  // register indices; byte address of the low word is four times the index
  // ==========================================================================
  localparam logic [9:0]  IDX_MISC_FEATURE    = 10'h1A0;
  localparam logic [9:0]  IDX_BRANCH_TOP      = 10'h1C9;
  localparam logic [9:0]  IDX_DEBUG_CONTROL   = 10'h1D9;
  localparam logic [9:0]  IDX_EXC_BRANCH_SRC  = 10'h1DD;
  localparam logic [9:0]  IDX_EXC_BRANCH_TGT  = 10'h1DE;
  localparam int          ADDR_W              = 16;
  localparam int          IDX_LSB             = 2;
  localparam int          IDX_MSB             = 11;
  localparam int          HIGH_WORD_BIT       = 12;

  // ==========================================================================
  // feature register fields
  // ==========================================================================
  localparam int          BIT_FIRST_THROTTLE  = 3;
  localparam int          BIT_SECOND_THROTTLE = 13;
  localparam int          BIT_FREQ_STEP       = 16;
  localparam int          BIT_MONITOR_WAIT    = 18;
  localparam int          BIT_LIMIT_LEAF      = 22;
  localparam int          BIT_EXEC_DIS_OFF    = 34;
  localparam logic [63:0] MISC_RW_MASK        = 64'h0000_0004_0045_2008;
  localparam logic [63:0] MISC_RESET          = 64'h0000_0000_0000_0000;
  localparam logic [63:0] DEBUG_RESET         = 64'h0000_0000_0000_0000;
  localparam int          TOP_INDEX_W         = 4;
  localparam int          THROTTLE_W          = 16;
  localparam logic [7:0]  LIMITED_LEAF        = 8'h03;
  localparam logic [7:0]  NATIVE_LEAF_DEFAULT = 8'h0A;

  // ==========================================================================
  // bus response codes
  // ==========================================================================
  localparam logic [1:0]  RESP_OKAY           = 2'h0;
  localparam logic [1:0]  RESP_SLVERR         = 2'h2;

endpackage : misc_enable_pkg

// ==== hw/branch_record_tracker.sv ====
// branch record tracker: top-of-stack index and last exception branch record
module branch_record_tracker
  import misc_enable_pkg::*;
(
  input  wire logic                   i_clk,
  input  wire logic                   i_sys_rst,
  input  wire logic                   i_branch_taken,
  input  wire logic [63:0]            i_branch_from,
  input  wire logic [63:0]            i_branch_to,
  input  wire logic                   i_exception,
  output logic      [TOP_INDEX_W-1:0] o_top_index,
  output logic      [63:0]            o_exc_from,
  output logic      [63:0]            o_exc_to
);

  typedef struct packed {
    logic [TOP_INDEX_W-1:0] top;
    logic [63:0]            last_from;
    logic [63:0]            last_to;
    logic [63:0]            exc_from;
    logic [63:0]            exc_to;
  } track_t;

  track_t track_reg;
  track_t track_next;

  // ==========================================================================
  // update
  // ==========================================================================
  // a branch in the same cycle as the exception is not before it, so the
  // exception record takes the branch recorded earlier
  always_comb begin
    track_next = track_reg;
    if (i_branch_taken) begin
      track_next.top       = track_reg.top + 4'h1;  // [R9]
      track_next.last_from = i_branch_from;
      track_next.last_to   = i_branch_to;
    end
    if (i_exception) begin
      track_next.exc_from = track_reg.last_from;  // [R11]
      track_next.exc_to   = track_reg.last_to;  // [R12]
    end
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      track_reg <= '0;
    end else begin
      track_reg <= track_next;
    end
  end

  assign o_top_index = track_reg.top;
  assign o_exc_from  = track_reg.exc_from;
  assign o_exc_to    = track_reg.exc_to;

  // ==========================================================================
  // checks
  // ==========================================================================
  property p_top_advance;
    @(posedge i_clk) disable iff (i_sys_rst)
    i_branch_taken |=> o_top_index == $past(o_top_index) + 4'h1;
  endproperty
  a_top_advance: assert property (p_top_advance) else $error("top index did not advance"); // [R9]

  property p_exc_source;
    @(posedge i_clk) disable iff (i_sys_rst)
    (i_branch_taken ##1 (i_exception && !i_branch_taken)) |=> o_exc_from == $past(i_branch_from, 2);
  endproperty
  a_exc_source: assert property (p_exc_source) else $error("exception source not captured"); // [R11]

  property p_exc_target;
    @(posedge i_clk) disable iff (i_sys_rst)
    !i_exception |=> $stable(o_exc_to) && $stable(o_exc_from);
  endproperty
  a_exc_target: assert property (p_exc_target) else $error("exception record changed without exception"); // [R12]

endmodule : branch_record_tracker

// ==== hw/misc_feature_bank.sv ====
// feature-enable, branch record and debug control register bank behind an AXI4-Lite slave
//
// Chosen here: the AXI4-Lite slave port.
module misc_feature_bank
  import misc_enable_pkg::*;
#(
  parameter logic [7:0] NATIVE_LEAF = NATIVE_LEAF_DEFAULT
)
(
  input  wire logic                   i_clk,
  input  wire logic                   i_sys_rst,
  // AXI4-Lite write address
  input  wire logic                   i_awvalid,
  output logic                        o_awready,
  input  wire logic [ADDR_W-1:0]      i_awaddr,
  input  wire logic [2:0]             i_awprot,
  // AXI4-Lite write data
  input  wire logic                   i_wvalid,
  output logic                        o_wready,
  input  wire logic [31:0]            i_wdata,
  input  wire logic [3:0]             i_wstrb,
  // AXI4-Lite write response
  output logic                        o_bvalid,
  input  wire logic                   i_bready,
  output logic      [1:0]             o_bresp,
  // AXI4-Lite read address
  input  wire logic                   i_arvalid,
  output logic                        o_arready,
  input  wire logic [ADDR_W-1:0]      i_araddr,
  input  wire logic [2:0]             i_arprot,
  // AXI4-Lite read data
  output logic                        o_rvalid,
  input  wire logic                   i_rready,
  output logic      [31:0]            o_rdata,
  output logic      [1:0]             o_rresp,
  // thermal sensing and throttle
  input  wire logic                   i_thermal_hot,
  input  wire logic [THROTTLE_W-1:0]  i_thermal_ctl_value,
  output logic                        o_first_throttle_en,
  output logic                        o_second_throttle_engaged,
  output logic      [THROTTLE_W-1:0]  o_ratio_voltage_setting,
  // feature controls
  output logic                        o_freq_step_en,
  output logic                        o_monitor_wait_en,
  output logic                        o_limit_leaf_en,
  output logic      [7:0]             o_reported_max_leaf,
  output logic                        o_exec_disable_off,
  output logic      [63:0]            o_debug_control,
  // branch events
  input  wire logic                   i_branch_taken,
  input  wire logic [63:0]            i_branch_from,
  input  wire logic [63:0]            i_branch_to,
  input  wire logic                   i_exception
);

  typedef struct packed {
    logic                  aw_held;
    logic [ADDR_W-1:0]     aw_addr;
    logic                  w_held;
    logic [31:0]           w_data;
    logic [3:0]            w_strb;
    logic                  bvalid;
    logic [1:0]            bresp;
    logic                  rvalid;
    logic [31:0]           rdata;
    logic [1:0]            rresp;
    logic [63:0]           misc;
    logic [63:0]           debug_ctl;
    logic                  engaged;
    logic [THROTTLE_W-1:0] setting;
    logic [7:0]            leaf;
  } bank_t;

  bank_t                  state_reg;
  bank_t                  state_next;
  logic [TOP_INDEX_W-1:0] top_index;
  logic [63:0]            exc_from;
  logic [63:0]            exc_to;
  logic                   wr_go;
  logic                   rd_go;

  // ==========================================================================
  // branch record tracker
  // ==========================================================================
  branch_record_tracker u_tracker (
    .i_clk          (i_clk),
    .i_sys_rst      (i_sys_rst),
    .i_branch_taken (i_branch_taken),
    .i_branch_from  (i_branch_from),
    .i_branch_to    (i_branch_to),
    .i_exception    (i_exception),
    .o_top_index    (top_index),
    .o_exc_from     (exc_from),
    .o_exc_to       (exc_to)
  );

  // ==========================================================================
  // helpers
  // ==========================================================================
  function automatic logic [31:0] merge_strb(input logic [31:0] old_w,
                                             input logic [31:0] new_w,
                                             input logic [3:0]  strb);
    logic [31:0] res;
    res = old_w;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[b*8 +: 8] = new_w[b*8 +: 8];
      end
    end
    return res;
  endfunction : merge_strb

  // upper address bits beyond the high-word window are unmapped
  function automatic logic addr_hit(input logic [ADDR_W-1:0] a);
    logic [9:0] idx;
    idx = a[IDX_MSB:IDX_LSB];
    if (a[ADDR_W-1:HIGH_WORD_BIT+1] != '0) begin
      return 1'b0;
    end
    return (idx == IDX_MISC_FEATURE) || (idx == IDX_BRANCH_TOP) || (idx == IDX_DEBUG_CONTROL) ||
           (idx == IDX_EXC_BRANCH_SRC) || (idx == IDX_EXC_BRANCH_TGT);
  endfunction : addr_hit

  function automatic logic [31:0] pick_word(input logic [63:0] v, input logic hi);
    return hi ? v[63:32] : v[31:0];
  endfunction : pick_word

  assign wr_go = state_reg.aw_held && state_reg.w_held && !state_reg.bvalid;
  assign rd_go = i_arvalid && o_arready;

  // ==========================================================================
  // next state
  // ==========================================================================
  always_comb begin
    logic [9:0]  widx;
    logic        whi;
    logic [63:0] tmp;
    logic [9:0]  ridx;
    logic        rhi;
    widx       = state_reg.aw_addr[IDX_MSB:IDX_LSB];
    whi        = state_reg.aw_addr[HIGH_WORD_BIT];
    ridx       = i_araddr[IDX_MSB:IDX_LSB];
    rhi        = i_araddr[HIGH_WORD_BIT];
    tmp        = '0;
    state_next = state_reg;

    // address and data may be taken in either order and are held until both are in
    if (i_awvalid && o_awready) begin
      state_next.aw_held = 1'b1;
      state_next.aw_addr = i_awaddr;
    end
    if (i_wvalid && o_wready) begin
      state_next.w_held = 1'b1;
      state_next.w_data = i_wdata;
      state_next.w_strb = i_wstrb;
    end

    if (wr_go) begin
      state_next.aw_held = 1'b0;
      state_next.w_held  = 1'b0;
      state_next.bvalid  = 1'b1;
      state_next.bresp   = addr_hit(state_reg.aw_addr) ? RESP_OKAY : RESP_SLVERR;
      if (addr_hit(state_reg.aw_addr) && widx == IDX_MISC_FEATURE) begin
        tmp = state_reg.misc;
        if (whi) begin
          tmp[63:32] = merge_strb(tmp[63:32], state_reg.w_data, state_reg.w_strb);
        end else begin
          tmp[31:0] = merge_strb(tmp[31:0], state_reg.w_data, state_reg.w_strb);
        end
        state_next.misc = tmp & MISC_RW_MASK;  // [R5] [R6] [R7] [R8] [R13] [R14]
      end
      if (addr_hit(state_reg.aw_addr) && widx == IDX_DEBUG_CONTROL) begin
        tmp = state_reg.debug_ctl;
        if (whi) begin
          tmp[63:32] = merge_strb(tmp[63:32], state_reg.w_data, state_reg.w_strb);
        end else begin
          tmp[31:0] = merge_strb(tmp[31:0], state_reg.w_data, state_reg.w_strb);
        end
        state_next.debug_ctl = tmp;  // [R10]
      end
    end else if (state_reg.bvalid && i_bready) begin
      state_next.bvalid = 1'b0;
    end

    // read-only registers take writes silently; unmapped addresses answer with an error
    if (rd_go) begin
      state_next.rvalid = 1'b1;
      state_next.rresp  = addr_hit(i_araddr) ? RESP_OKAY : RESP_SLVERR;
      state_next.rdata  = 32'h0000_0000;
      if (addr_hit(i_araddr)) begin
        unique case (ridx)
          IDX_MISC_FEATURE:   state_next.rdata = pick_word(state_reg.misc & MISC_RW_MASK, rhi);  // [R14]
          IDX_BRANCH_TOP:     state_next.rdata = pick_word({60'h0, top_index}, rhi);  // [R9]
          IDX_DEBUG_CONTROL:  state_next.rdata = pick_word(state_reg.debug_ctl, rhi);  // [R10]
          IDX_EXC_BRANCH_SRC: state_next.rdata = pick_word(exc_from, rhi);  // [R11]
          IDX_EXC_BRANCH_TGT: state_next.rdata = pick_word(exc_to, rhi);  // [R12]
          default:            state_next.rdata = 32'h0000_0000;
        endcase
      end
    end else if (state_reg.rvalid && i_rready) begin
      state_next.rvalid = 1'b0;
    end

    // throttle: setting only moves while the second throttle is enabled and the die is hot
    if (state_reg.misc[BIT_SECOND_THROTTLE] && i_thermal_hot) begin
      state_next.engaged = 1'b1;  // [R1]
      state_next.setting = i_thermal_ctl_value;  // [R1]
    end else begin
      state_next.engaged = 1'b0;  // [R2]
    end

    // limiting the leaf breaks software that probes leaves above three
    state_next.leaf = state_reg.misc[BIT_LIMIT_LEAF] ? LIMITED_LEAF : NATIVE_LEAF;  // [R7]
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      state_reg           <= '0;
      state_reg.misc      <= MISC_RESET;  // [R2]
      state_reg.debug_ctl <= DEBUG_RESET;
      state_reg.leaf      <= NATIVE_LEAF;
    end else begin
      state_reg <= state_next;
    end
  end

  // ==========================================================================
  // outputs
  // ==========================================================================
  assign o_awready                 = !state_reg.aw_held && !state_reg.bvalid;
  assign o_wready                  = !state_reg.w_held && !state_reg.bvalid;
  assign o_arready                 = !state_reg.rvalid;
  assign o_bvalid                  = state_reg.bvalid;
  assign o_bresp                   = state_reg.bresp;
  assign o_rvalid                  = state_reg.rvalid;
  assign o_rdata                   = state_reg.rdata;
  assign o_rresp                   = state_reg.rresp;
  assign o_first_throttle_en       = state_reg.misc[BIT_FIRST_THROTTLE];  // [R13]
  assign o_second_throttle_engaged = state_reg.engaged;
  assign o_ratio_voltage_setting   = state_reg.setting;
  assign o_freq_step_en            = state_reg.misc[BIT_FREQ_STEP];  // [R5]
  assign o_monitor_wait_en         = state_reg.misc[BIT_MONITOR_WAIT];  // [R6]
  assign o_limit_leaf_en           = state_reg.misc[BIT_LIMIT_LEAF];
  assign o_reported_max_leaf       = state_reg.leaf;
  assign o_exec_disable_off        = state_reg.misc[BIT_EXEC_DIS_OFF];  // [R8]
  assign o_debug_control           = state_reg.debug_ctl;

  // ==========================================================================
  // checks
  // ==========================================================================
  logic misc_lo_wr;
  logic misc_hi_wr;
  logic dbg_lo_wr;
  logic misc_rd;
  assign misc_lo_wr = wr_go && state_reg.aw_addr == {4'h0, IDX_MISC_FEATURE, 2'h0};
  assign misc_hi_wr = wr_go && state_reg.aw_addr == {4'h1, IDX_MISC_FEATURE, 2'h0};
  assign dbg_lo_wr  = wr_go && state_reg.aw_addr == {4'h0, IDX_DEBUG_CONTROL, 2'h0};
  assign misc_rd    = rd_go && i_araddr == {4'h0, IDX_MISC_FEATURE, 2'h0};

  property p_throttle_engage;
    @(posedge i_clk) disable iff (i_sys_rst)
    (o_second_throttle_engaged == 1'b0 && state_reg.misc[BIT_SECOND_THROTTLE] && i_thermal_hot)
      |=> o_second_throttle_engaged && o_ratio_voltage_setting == $past(i_thermal_ctl_value);
  endproperty
  a_throttle_engage: assert property (p_throttle_engage) else $error("throttle not engaged when hot"); // [R1]

  property p_throttle_hold;
    @(posedge i_clk) disable iff (i_sys_rst)
    !state_reg.misc[BIT_SECOND_THROTTLE] |=> $stable(o_ratio_voltage_setting) && !o_second_throttle_engaged;
  endproperty
  a_throttle_hold: assert property (p_throttle_hold) else $error("setting moved while throttle disabled"); // [R2]

  property p_freq_step;
    @(posedge i_clk) disable iff (i_sys_rst)
    (misc_lo_wr && state_reg.w_strb[2]) |=> o_freq_step_en == $past(state_reg.w_data[BIT_FREQ_STEP]);
  endproperty
  a_freq_step: assert property (p_freq_step) else $error("stepping enable not written"); // [R5]

  property p_monitor_wait;
    @(posedge i_clk) disable iff (i_sys_rst)
    (misc_lo_wr && state_reg.w_strb[2]) |=> o_monitor_wait_en == $past(state_reg.w_data[BIT_MONITOR_WAIT]);
  endproperty
  a_monitor_wait: assert property (p_monitor_wait) else $error("monitor enable not written"); // [R6]

  property p_leaf_limit;
    @(posedge i_clk) disable iff (i_sys_rst)
    o_limit_leaf_en |=> o_reported_max_leaf == LIMITED_LEAF;
  endproperty
  a_leaf_limit: assert property (p_leaf_limit) else $error("leaf not limited to three"); // [R7]

  property p_exec_disable;
    @(posedge i_clk) disable iff (i_sys_rst)
    (misc_hi_wr && state_reg.w_strb[0]) |=> o_exec_disable_off == $past(state_reg.w_data[2]);
  endproperty
  a_exec_disable: assert property (p_exec_disable) else $error("execute-disable bit not written"); // [R8]

  property p_debug_write;
    @(posedge i_clk) disable iff (i_sys_rst)
    (dbg_lo_wr && state_reg.w_strb == 4'hF) |=> o_bvalid && o_debug_control[31:0] == $past(state_reg.w_data);
  endproperty
  a_debug_write: assert property (p_debug_write) else $error("debug control not written"); // [R10]

  property p_first_throttle;
    @(posedge i_clk) disable iff (i_sys_rst)
    (misc_lo_wr && state_reg.w_strb[0]) |=> o_first_throttle_en == $past(state_reg.w_data[BIT_FIRST_THROTTLE]);
  endproperty
  a_first_throttle: assert property (p_first_throttle) else $error("first throttle enable not written"); // [R13]

  property p_reserved_zero;
    @(posedge i_clk) disable iff (i_sys_rst)
    misc_rd |=> o_rvalid && (o_rdata & ~MISC_RW_MASK[31:0]) == 32'h0000_0000;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved feature bits read nonzero"); // [R14]

endmodule : misc_feature_bank

// ==== verification/misc_feature_bank_tb.sv ====
// testbench for the feature-enable, debug control and branch record register bank
module misc_feature_bank_tb
  import misc_enable_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================================
  // stimulus and observed signals
  // ==========================================================================
  logic                  i_clk = 1'b0, i_sys_rst = 1'b1, i_thermal_hot = 1'b0;
  logic                  i_awvalid = 1'b0, i_wvalid = 1'b0, i_bready = 1'b0, i_arvalid = 1'b0, i_rready = 1'b0;
  logic                  i_branch_taken = 1'b0, i_exception = 1'b0;
  logic [ADDR_W-1:0]     i_awaddr = '0, i_araddr = '0;
  logic [31:0]           i_wdata = '0, o_rdata;
  logic [THROTTLE_W-1:0] i_thermal_ctl_value = '0, o_ratio_voltage_setting;
  logic [63:0]           i_branch_from = '0, i_branch_to = '0, o_debug_control;
  logic [1:0]            o_bresp, o_rresp;
  logic [7:0]            o_reported_max_leaf;
  logic                  o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_first_throttle_en;
  logic                  o_second_throttle_engaged, o_freq_step_en, o_monitor_wait_en, o_limit_leaf_en;
  logic                  o_exec_disable_off;
  int                    num_errors = 0, checked = 0;

  misc_feature_bank #(.NATIVE_LEAF(NATIVE_LEAF_DEFAULT)) dut_u (
    .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_awvalid(i_awvalid), .o_awready(o_awready), .i_awaddr(i_awaddr),
    .i_awprot(3'h0), .i_wvalid(i_wvalid), .o_wready(o_wready), .i_wdata(i_wdata), .i_wstrb(4'hF),
    .o_bvalid(o_bvalid), .i_bready(i_bready), .o_bresp(o_bresp), .i_arvalid(i_arvalid), .o_arready(o_arready),
    .i_araddr(i_araddr), .i_arprot(3'h0), .o_rvalid(o_rvalid), .i_rready(i_rready), .o_rdata(o_rdata),
    .o_rresp(o_rresp), .i_thermal_hot(i_thermal_hot), .i_thermal_ctl_value(i_thermal_ctl_value),
    .o_first_throttle_en(o_first_throttle_en), .o_second_throttle_engaged(o_second_throttle_engaged),
    .o_ratio_voltage_setting(o_ratio_voltage_setting), .o_freq_step_en(o_freq_step_en),
    .o_monitor_wait_en(o_monitor_wait_en), .o_limit_leaf_en(o_limit_leaf_en),
    .o_reported_max_leaf(o_reported_max_leaf), .o_exec_disable_off(o_exec_disable_off),
    .o_debug_control(o_debug_control), .i_branch_taken(i_branch_taken), .i_branch_from(i_branch_from),
    .i_branch_to(i_branch_to), .i_exception(i_exception));

  always #2.5 i_clk = ~i_clk;

  // ==========================================================================
  // helpers
  // ==========================================================================
  task automatic close_out();
    if (num_errors == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : close_out

  task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  function automatic logic [15:0] lo_addr(input logic [9:0] idx);
    return {4'h0, idx, 2'h0};
  endfunction : lo_addr

  function automatic logic [7:0] exp_leaf(input logic [63:0] f);
    return f[BIT_LIMIT_LEAF] ? LIMITED_LEAF : NATIVE_LEAF_DEFAULT;
  endfunction : exp_leaf

  // write: address and data offered together, each dropped once taken; one idle edge after
  task automatic axw(input logic [15:0] a, input logic [31:0] d, output logic [1:0] r);
    i_awaddr  <= a;
    i_wdata   <= d;
    i_awvalid <= 1'b1;
    i_wvalid  <= 1'b1;
    i_bready  <= 1'b1;
    forever begin
      @(posedge i_clk);
      if (i_awvalid && o_awready) i_awvalid <= 1'b0;
      if (i_wvalid && o_wready) i_wvalid <= 1'b0;
      if (o_bvalid) begin
        r = o_bresp;
        i_bready <= 1'b0;
        break;
      end
    end
    @(posedge i_clk);
  endtask : axw

  task automatic axr(input logic [15:0] a, output logic [31:0] q, output logic [1:0] r);
    i_araddr  <= a;
    i_arvalid <= 1'b1;
    i_rready  <= 1'b1;
    forever begin
      @(posedge i_clk);
      if (i_arvalid && o_arready) i_arvalid <= 1'b0;
      if (o_rvalid) begin
        q = o_rdata;
        r = o_rresp;
        i_rready <= 1'b0;
        break;
      end
    end
    @(posedge i_clk);
  endtask : axr

  // 64-bit register as two words: low word at the index, high word in the upper window
  task automatic wr64(input logic [9:0] idx, input logic [63:0] d);
    logic [1:0] r;
    axw(lo_addr(idx), d[31:0], r);
    chk("wresp_lo", RESP_OKAY, r);
    axw(lo_addr(idx) | 16'h1000, d[63:32], r);
    chk("wresp_hi", RESP_OKAY, r);
  endtask : wr64

  task automatic rd64(input logic [9:0] idx, output logic [63:0] q);
    logic [1:0] r;
    axr(lo_addr(idx), q[31:0], r);
    chk("rresp_lo", RESP_OKAY, r);
    axr(lo_addr(idx) | 16'h1000, q[63:32], r);
    chk("rresp_hi", RESP_OKAY, r);
  endtask : rd64

  // ==========================================================================
  // main sequence and watchdog
  // ==========================================================================
  initial begin
    #100us;
    num_errors++;
    close_out();
  end

  initial begin
    logic [63:0] d, q, f, ef, et;
    logic [15:0] ctl, es;
    logic [31:0] w;
    logic [1:0]  r;
    logic        hot;
    int          n;
    void'($urandom(50));
    f  = '0;
    es = '0;
    repeat (4) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    @(posedge i_clk);
    chk("leaf_rst", NATIVE_LEAF_DEFAULT, o_reported_max_leaf);
    chk("engaged_rst", 1'b0, o_second_throttle_engaged);
    rd64(IDX_MISC_FEATURE, q);
    chk("feature_rst", MISC_RESET, q);
    // random feature words with all-ones and all-zeros-but-bit-3 corners; sensor and throttle value moving too
    for (int i = 0; i < 14; i++) begin
      d   = (i == 0) ? '1 : (i == 1) ? '0 : {$urandom, $urandom};
      // bit 13 is written freely: the modelled part reports the second throttle in leaf 1
      if (!d[BIT_FIRST_THROTTLE] && !d[BIT_SECOND_THROTTLE]) d[BIT_FIRST_THROTTLE] = 1'b1;
      hot = (i < 2) ? 1'b1 : 1'($urandom);
      ctl = 16'($urandom);
      i_thermal_hot       <= hot;
      i_thermal_ctl_value <= ctl;
      if (hot && (f[BIT_SECOND_THROTTLE] || d[BIT_SECOND_THROTTLE])) es = ctl;
      wr64(IDX_MISC_FEATURE, d);
      f = d & MISC_RW_MASK;
      repeat (2) @(posedge i_clk);
      rd64(IDX_MISC_FEATURE, q);
      chk("feature", f, q);
      chk("first_throttle", f[BIT_FIRST_THROTTLE], o_first_throttle_en);
      chk("freq_step", f[BIT_FREQ_STEP], o_freq_step_en);
      chk("monitor_wait", f[BIT_MONITOR_WAIT], o_monitor_wait_en);
      chk("limit_leaf", f[BIT_LIMIT_LEAF], o_limit_leaf_en);
      chk("max_leaf", exp_leaf(f), o_reported_max_leaf);
      chk("exec_dis_off", f[BIT_EXEC_DIS_OFF], o_exec_disable_off);
      chk("engaged", f[BIT_SECOND_THROTTLE] & hot, o_second_throttle_engaged);
      chk("ratio_voltage", es, o_ratio_voltage_setting);
    end
    for (int i = 0; i < 3; i++) begin
      d = (i == 0) ? '1 : {$urandom, $urandom};
      wr64(IDX_DEBUG_CONTROL, d);
      rd64(IDX_DEBUG_CONTROL, q);
      chk("debug_read", d, q);
      chk("debug_out", d, o_debug_control);
    end
    // past a wrap of the ring; exception lands together with one more branch, which it must not see
    n = 17 + int'($urandom % 4);
    for (int k = 0; k < n; k++) begin
      @(posedge i_clk);
      ef = {$urandom, $urandom};
      et = {$urandom, $urandom};
      i_branch_taken <= 1'b1;
      i_branch_from  <= ef;
      i_branch_to    <= et;
    end
    @(posedge i_clk);
    i_exception   <= 1'b1;
    i_branch_from <= ~ef;
    i_branch_to   <= ~et;
    @(posedge i_clk);
    i_exception    <= 1'b0;
    i_branch_taken <= 1'b0;
    @(posedge i_clk);
    rd64(IDX_BRANCH_TOP, q);
    chk("top_index", 64'((n + 1) % 16), q);
    rd64(IDX_EXC_BRANCH_SRC, q);
    chk("exc_source", ef, q);
    rd64(IDX_EXC_BRANCH_TGT, q);
    chk("exc_target", et, q);
    axw(lo_addr(IDX_EXC_BRANCH_SRC), ~ef[31:0], r);
    chk("ro_wresp", RESP_OKAY, r);
    rd64(IDX_EXC_BRANCH_SRC, q);
    chk("ro_unchanged", ef, q);
    axr(16'hE000, w, r);
    chk("unmapped_rresp", RESP_SLVERR, r);
    chk("unmapped_rdata", 32'h0000_0000, w);
    axw(16'hE000, 32'hFFFF_FFFF, r);
    chk("unmapped_wresp", RESP_SLVERR, r);
    // one branch, then an exception alone: the record takes that branch
    @(posedge i_clk);
    i_branch_taken <= 1'b1;
    @(posedge i_clk);
    i_branch_taken <= 1'b0;
    i_exception    <= 1'b1;
    @(posedge i_clk);
    i_exception <= 1'b0;
    rd64(IDX_EXC_BRANCH_SRC, q);
    chk("exc_source_alone", ~ef, q);
    rd64(IDX_EXC_BRANCH_TGT, q);
    chk("exc_target_alone", ~et, q);
    close_out();
  end
endmodule : misc_feature_bank_tb
